// [hdl/touch_host_pkg.sv]
// shared constants and types of the touch panel serial host
package touch_host_pkg;

  // ===========================================================
  // clock and bus timing
  localparam int CLK_NS = 20;
  localparam int T_SCL_LOW_NS = 1300;
  localparam int QTR_CYC = (T_SCL_LOW_NS + 2 * CLK_NS - 1) / (2 * CLK_NS);
  localparam int LOW_MIN_CYC = (T_SCL_LOW_NS + CLK_NS - 1) / CLK_NS;
  localparam int QCNT_W = 6;

  // ===========================================================
  // address strap sequence
  localparam int T_STRAP_RST_US = 100;
  localparam int T_STRAP_HOLD_US = 100;
  localparam int T_STRAP_WAIT_US = 5000;
  localparam int STRAP_RST_CYC = T_STRAP_RST_US * 1000 / CLK_NS;
  localparam int STRAP_HOLD_CYC = T_STRAP_HOLD_US * 1000 / CLK_NS;
  localparam int STRAP_WAIT_CYC = T_STRAP_WAIT_US * 1000 / CLK_NS;
  localparam int TMR_W = 20;

  // ===========================================================
  // target addresses and widths
  localparam logic [7:0] ADDR_A_WR = 8'hBA;
  localparam logic [7:0] ADDR_B_WR = 8'h28;
  localparam int DATA_W = 8;
  localparam int PTR_W = 16;
  localparam logic [3:0] ACK_SLOT = 4'h8;
  localparam logic [3:0] LAST_DATA_BIT = 4'h7;

  typedef enum logic [1:0] {OP_START, OP_STOP, OP_BIT} bit_op_t;

  typedef enum logic [3:0] {
    ST_RST, ST_HOLD, ST_WAIT, ST_IDLE, ST_START, ST_ADDR_W, ST_PTR_HI,
    ST_PTR_LO, ST_WDATA, ST_RSTART, ST_ADDR_R, ST_RDATA, ST_STOP
  } state_t;

endpackage : touch_host_pkg

// [hdl/bit_if.sv]
// bit level request and answer between sequencer and bus engine
`timescale 1ns/1ps
interface bit_if;
  import touch_host_pkg::*;
  logic go;
  bit_op_t op;
  logic tx;
  logic done;
  logic rx;
  modport ctl (output go, op, tx, input done, rx);
  modport eng (input go, op, tx, output done, rx);
endinterface : bit_if

// [hdl/touch_pair_fifo.sv]
// two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
module touch_pair_fifo #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  logic [WIDTH-1:0] d0_ff;
  logic [WIDTH-1:0] d1_ff;
  logic v0_ff;
  logic v1_ff;
  logic rdy_ff;
  logic push;
  logic pop;
  logic nxt_v0;
  logic nxt_v1;

  assign push = in_valid && rdy_ff;
  assign pop = v0_ff && out_ready;
  assign nxt_v1 = v1_ff ? !pop : (push && v0_ff && !pop);
  assign nxt_v0 = v0_ff ? (!pop || v1_ff || push) : push;
  assign in_ready = rdy_ff;
  assign out_valid = v0_ff;
  assign out_data = d0_ff;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      v0_ff <= 1'b0;
      v1_ff <= 1'b0;
      rdy_ff <= 1'b1;
    end else begin
      v0_ff <= nxt_v0;
      v1_ff <= nxt_v1;
      rdy_ff <= !nxt_v1;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      d0_ff <= '0;
      d1_ff <= '0;
    end else begin
      if (pop && v1_ff) begin
        d0_ff <= d1_ff;
      end else if (push && (!v0_ff || pop)) begin
        d0_ff <= in_data;
      end
      if (push && v0_ff && !pop) begin
        d1_ff <= in_data;
      end
    end
  end

endmodule : touch_pair_fifo

// [hdl/touch_bit_engine.sv]
// open-drain bus engine: start, stop and single bit slots
`timescale 1ns/1ps
module touch_bit_engine (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // requests from the sequencer
  bit_if.eng bus,
  // bus pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic scl_oe,
  output logic sda_oe
);
  import touch_host_pkg::*;

  logic scl_s1_ff;
  logic scl_s2_ff;
  logic sda_s1_ff;
  logic sda_s2_ff;
  logic busy_ff;
  logic [1:0] phase_ff;
  logic [QCNT_W-1:0] qcnt_ff;
  bit_op_t op_ff;
  logic scl_oe_ff;
  logic sda_oe_ff;
  logic rx_ff;
  logic done_ff;
  logic [7:0] lowcnt_ff;
  logic stretch;
  logic tick;

  assign scl_oe = scl_oe_ff;
  assign sda_oe = sda_oe_ff;
  assign bus.done = done_ff;
  assign bus.rx = rx_ff;
  // a target holding the clock low freezes the first high quarter
  assign stretch = (phase_ff == 2'h1) && !scl_s2_ff;
  assign tick = busy_ff && !stretch &&
                (qcnt_ff == QCNT_W'(QTR_CYC - 1));

  // ===========================================================
  // pin synchronisers
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      scl_s1_ff <= 1'b1;
      scl_s2_ff <= 1'b1;
      sda_s1_ff <= 1'b1;
      sda_s2_ff <= 1'b1;
    end else begin
      scl_s1_ff <= scl_i;
      scl_s2_ff <= scl_s1_ff;
      sda_s1_ff <= sda_i;
      sda_s2_ff <= sda_s1_ff;
    end
  end

  // ===========================================================
  // quarter timing
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      busy_ff <= 1'b0;
      phase_ff <= 2'h0;
      qcnt_ff <= '0;
      op_ff <= OP_STOP;
    end else if (!busy_ff) begin
      if (bus.go) begin
        busy_ff <= 1'b1;
        phase_ff <= 2'h0;
        qcnt_ff <= '0;
        op_ff <= bus.op;
      end
    end else if (stretch) begin
      qcnt_ff <= '0;
    end else if (tick) begin
      qcnt_ff <= '0;
      phase_ff <= phase_ff + 2'h1;
      if (phase_ff == 2'h3) begin
        busy_ff <= 1'b0;
      end
    end else begin
      qcnt_ff <= qcnt_ff + QCNT_W'(1);
    end
  end

  // ===========================================================
  // pin drive and sampling
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      scl_oe_ff <= 1'b0;
      sda_oe_ff <= 1'b0;
      rx_ff <= 1'b1;
    end else if (!busy_ff && bus.go) begin
      case (bus.op)
        OP_START: sda_oe_ff <= 1'b0;
        OP_STOP: sda_oe_ff <= 1'b1;
        default: sda_oe_ff <= !bus.tx;
      endcase
    end else if (tick) begin
      case (phase_ff)
        2'h0: scl_oe_ff <= 1'b0;
        2'h1: begin
          if (op_ff == OP_START) begin
            sda_oe_ff <= 1'b1;
          end else if (op_ff == OP_STOP) begin
            sda_oe_ff <= 1'b0;
          end else begin
            rx_ff <= sda_s2_ff;
          end
        end
        2'h2: begin
          if (op_ff != OP_STOP) begin
            scl_oe_ff <= 1'b1;
          end
        end
        default: scl_oe_ff <= scl_oe_ff;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      done_ff <= 1'b0;
    end else begin
      done_ff <= tick && (phase_ff == 2'h3);
    end
  end

  // cycles the clock line has been held low, for checking only
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      lowcnt_ff <= 8'h00;
    end else if (!scl_oe_ff) begin
      lowcnt_ff <= 8'h00;
    end else if (lowcnt_ff != 8'hFF) begin
      lowcnt_ff <= lowcnt_ff + 8'h01;
    end
  end

  // ===========================================================
  // checks
  chk_data_while_high: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    (busy_ff && op_ff == OP_BIT && !scl_oe_ff && !$past(scl_oe_ff))
      |-> $stable(sda_oe_ff))
    else $error("data changed while clock released");
  chk_start_edge: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    (op_ff == OP_START && $rose(sda_oe_ff)) |-> !scl_oe_ff ##1 scl_oe_ff
      [*1] or (!scl_oe_ff [*2]))
    else $error("start without clock high");
  chk_stop_edge: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    (busy_ff && op_ff == OP_STOP && $fell(sda_oe_ff)) |-> !scl_oe_ff)
    else $error("stop without clock high");
  chk_scl_low_time: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    $fell(scl_oe_ff) |-> $past(lowcnt_ff) >= 8'(LOW_MIN_CYC - 1))
    else $error("clock low period too short");

endmodule : touch_bit_engine

// [hdl/touch_host_i2c.sv]
// host controller for the touch panel serial port and address strap
//
// Notes on behaviour
// - Bus bit rate stays at or below 400kbps.
// - Host straps address via reset and interrupt.
// - Start: data falls while clock high.
// - Stop: data rises while clock high.
// - Byte is eight bits plus acknowledge slot.
// - Data sampled high clock, changes low clock.
// - Write: address, 16-bit pointer, data bytes.
// - Burst write runs until host stop.
// - Read first sets pointer in write phase.
// - Repeated start then read address byte.
// - Host acknowledges all but last, then stops.
`timescale 1ns/1ps
module touch_host_i2c #(
  parameter int STRAP_RST_CYC = touch_host_pkg::STRAP_RST_CYC,
  parameter int STRAP_HOLD_CYC = touch_host_pkg::STRAP_HOLD_CYC,
  parameter int STRAP_WAIT_CYC = touch_host_pkg::STRAP_WAIT_CYC
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // address pair choice, caught during the strap
  input wire logic addr_sel,
  // command
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cmd_read,
  input wire logic [touch_host_pkg::PTR_W-1:0] cmd_reg,
  input wire logic [7:0] cmd_len,
  // write data
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [touch_host_pkg::DATA_W-1:0] wr_data,
  // read data
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [touch_host_pkg::DATA_W-1:0] rd_data,
  // status
  output logic init_done,
  output logic nack_err,
  output logic touch_irq,
  // panel pins
  output logic tp_rstn,
  input wire logic int_i,
  output logic int_o,
  output logic int_oe,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe
);
  import touch_host_pkg::*;

  bit_if bus_i ();

  state_t state_ff;
  state_t nxt_state;
  logic [TMR_W-1:0] tmr_ff;
  logic sel_ff;
  logic tp_rstn_ff;
  logic int_oe_ff;
  logic int_o_ff;
  logic int_s1_ff;
  logic int_s2_ff;
  logic irq_ff;
  logic zero_ff;
  logic cmd_ready_ff;
  logic init_done_ff;
  logic nack_err_ff;
  logic read_ff;
  logic [PTR_W-1:0] reg_ff;
  logic [7:0] left_ff;
  logic [3:0] bit_idx_ff;
  logic [7:0] sh_ff;
  logic go_ff;
  logic pend_ff;
  logic tx_ff;
  bit_op_t op_ff;
  logic [7:0] addr_wr;
  logic bit_done;
  logic byte_end;
  logic nack;
  logic last;
  logic byte_state;
  logic data_ok;
  logic issue;
  logic tx_bit;
  bit_op_t op_bit;
  logic wq_valid;
  logic wq_pop;
  logic [7:0] wq_data;
  logic rq_push;
  logic rq_ready;

  assign bus_i.go = go_ff;
  assign bus_i.op = op_ff;
  assign bus_i.tx = tx_ff;
  assign bit_done = bus_i.done;
  assign nack = bus_i.rx;
  assign byte_end = bit_done && (bit_idx_ff == ACK_SLOT);
  assign last = (left_ff <= 8'h01);
  assign addr_wr = sel_ff ? ADDR_B_WR : ADDR_A_WR;

  assign cmd_ready = cmd_ready_ff;
  assign init_done = init_done_ff;
  assign nack_err = nack_err_ff;
  assign touch_irq = irq_ff;
  assign tp_rstn = tp_rstn_ff;
  assign int_o = int_o_ff;
  assign int_oe = int_oe_ff;
  assign scl_o = zero_ff;
  assign sda_o = zero_ff;

  // ===========================================================
  // sequence of a transfer
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_RST: if (tmr_ff == '0) nxt_state = ST_HOLD;
      ST_HOLD: if (tmr_ff == '0) nxt_state = ST_WAIT;
      ST_WAIT: if (tmr_ff == '0) nxt_state = ST_IDLE;
      ST_IDLE: if (cmd_valid && cmd_ready_ff) nxt_state = ST_START;
      ST_START: if (bit_done) nxt_state = ST_ADDR_W;
      ST_ADDR_W: if (byte_end) nxt_state = nack ? ST_STOP : ST_PTR_HI;
      ST_PTR_HI: if (byte_end) nxt_state = nack ? ST_STOP : ST_PTR_LO;
      ST_PTR_LO: begin
        if (byte_end) begin
          if (nack) begin
            nxt_state = ST_STOP;
          end else if (read_ff) begin
            nxt_state = ST_RSTART;
          end else begin
            nxt_state = (left_ff == 8'h00) ? ST_STOP : ST_WDATA;
          end
        end
      end
      ST_WDATA: if (byte_end && (nack || last)) nxt_state = ST_STOP;
      ST_RSTART: if (bit_done) nxt_state = ST_ADDR_R;
      ST_ADDR_R: if (byte_end) nxt_state = nack ? ST_STOP : ST_RDATA;
      ST_RDATA: if (byte_end && last) nxt_state = ST_STOP;
      ST_STOP: if (bit_done) nxt_state = ST_IDLE;
      default: nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state_ff <= ST_RST;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ===========================================================
  // address strap on reset and interrupt lines
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      tmr_ff <= TMR_W'(STRAP_RST_CYC - 1);
    end else if (nxt_state == ST_HOLD && state_ff != ST_HOLD) begin
      tmr_ff <= TMR_W'(STRAP_HOLD_CYC - 1);
    end else if (nxt_state == ST_WAIT && state_ff != ST_WAIT) begin
      tmr_ff <= TMR_W'(STRAP_WAIT_CYC - 1);
    end else if (tmr_ff != '0) begin
      tmr_ff <= tmr_ff - TMR_W'(1);
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      sel_ff <= 1'b0;
      tp_rstn_ff <= 1'b0;
      int_oe_ff <= 1'b1;
      int_o_ff <= 1'b0;
    end else begin
      if (state_ff == ST_RST) begin
        sel_ff <= addr_sel;
      end
      tp_rstn_ff <= (nxt_state != ST_RST);
      int_oe_ff <= (nxt_state == ST_RST) || (nxt_state == ST_HOLD);
      int_o_ff <= sel_ff;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      int_s1_ff <= 1'b0;
      int_s2_ff <= 1'b0;
      irq_ff <= 1'b0;
      zero_ff <= 1'b0;
    end else begin
      int_s1_ff <= int_i;
      int_s2_ff <= int_s1_ff;
      irq_ff <= int_s2_ff && init_done_ff;
      zero_ff <= 1'b0;
    end
  end

  // ===========================================================
  // command and status
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cmd_ready_ff <= 1'b0;
      init_done_ff <= 1'b0;
      nack_err_ff <= 1'b0;
      read_ff <= 1'b0;
      reg_ff <= '0;
    end else begin
      cmd_ready_ff <= (nxt_state == ST_IDLE);
      if (nxt_state == ST_IDLE) begin
        init_done_ff <= 1'b1;
      end
      if (state_ff == ST_IDLE && cmd_valid && cmd_ready_ff) begin
        nack_err_ff <= 1'b0;
        read_ff <= cmd_read;
        reg_ff <= cmd_reg;
      end else if (byte_end && nack && state_ff != ST_RDATA) begin
        nack_err_ff <= 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      left_ff <= 8'h00;
    end else if (state_ff == ST_IDLE && cmd_valid && cmd_ready_ff) begin
      left_ff <= cmd_len;
    end else if (byte_end && (state_ff == ST_WDATA || state_ff == ST_RDATA)
                 && left_ff != 8'h00) begin
      left_ff <= left_ff - 8'h01;
    end
  end

  // ===========================================================
  // bit slots within a byte
  always_comb begin
    byte_state = 1'b0;
    op_bit = OP_BIT;
    case (state_ff)
      ST_START, ST_RSTART: op_bit = OP_START;
      ST_STOP: op_bit = OP_STOP;
      ST_ADDR_W, ST_PTR_HI, ST_PTR_LO, ST_WDATA, ST_ADDR_R, ST_RDATA:
        byte_state = 1'b1;
      default: op_bit = OP_BIT;
    endcase
  end

  always_comb begin
    if (bit_idx_ff == ACK_SLOT) begin
      tx_bit = (state_ff == ST_RDATA) ? last : 1'b1;
    end else if (state_ff == ST_RDATA) begin
      tx_bit = 1'b1;
    end else if (state_ff == ST_WDATA && bit_idx_ff == 4'h0) begin
      tx_bit = wq_data[7];
    end else begin
      tx_bit = sh_ff[7];
    end
  end

  // the write buffer must hold a whole byte, and the read buffer have room for one, before its first slot
  assign data_ok = (bit_idx_ff != 4'h0) ||
                   (state_ff == ST_WDATA ? wq_valid :
                    state_ff == ST_RDATA ? rq_ready : 1'b1);
  assign issue = !pend_ff && !go_ff && data_ok &&
                 (byte_state || op_bit != OP_BIT);
  assign wq_pop = issue && state_ff == ST_WDATA && bit_idx_ff == 4'h0;
  assign rq_push = bit_done && state_ff == ST_RDATA &&
                   bit_idx_ff == LAST_DATA_BIT;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      go_ff <= 1'b0;
      pend_ff <= 1'b0;
      tx_ff <= 1'b1;
      op_ff <= OP_STOP;
    end else begin
      go_ff <= issue;
      if (issue) begin
        pend_ff <= 1'b1;
        tx_ff <= tx_bit;
        op_ff <= op_bit;
      end else if (bit_done) begin
        pend_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      bit_idx_ff <= 4'h0;
    end else if (nxt_state != state_ff || byte_end) begin
      bit_idx_ff <= 4'h0;
    end else if (bit_done && byte_state) begin
      bit_idx_ff <= bit_idx_ff + 4'h1;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      sh_ff <= 8'h00;
    end else if (nxt_state != state_ff) begin
      case (nxt_state)
        ST_ADDR_W: sh_ff <= addr_wr;
        ST_PTR_HI: sh_ff <= reg_ff[15:8];
        ST_PTR_LO: sh_ff <= reg_ff[7:0];
        ST_ADDR_R: sh_ff <= addr_wr | 8'h01;
        default: sh_ff <= sh_ff;
      endcase
    end else if (issue && byte_state && state_ff != ST_RDATA
                 && bit_idx_ff != ACK_SLOT) begin
      sh_ff <= wq_pop ? {wq_data[6:0], 1'b0} : {sh_ff[6:0], 1'b0};
    end else if (bit_done && state_ff == ST_RDATA
                 && bit_idx_ff != ACK_SLOT) begin
      sh_ff <= {sh_ff[6:0], nack};
    end
  end

  // ===========================================================
  // engine and data buffers
  touch_bit_engine u_engine (
    .sys_clk (sys_clk),
    .rstn (rstn),
    .bus (bus_i),
    .scl_i (scl_i),
    .sda_i (sda_i),
    .scl_oe (scl_oe),
    .sda_oe (sda_oe)
  );

  touch_pair_fifo #(.WIDTH(DATA_W)) u_wr_fifo (
    .sys_clk (sys_clk),
    .rstn (rstn),
    .in_valid (wr_valid),
    .in_ready (wr_ready),
    .in_data (wr_data),
    .out_valid (wq_valid),
    .out_ready (wq_pop),
    .out_data (wq_data)
  );

  touch_pair_fifo #(.WIDTH(DATA_W)) u_rd_fifo (
    .sys_clk (sys_clk),
    .rstn (rstn),
    .in_valid (rq_push),
    .in_ready (rq_ready),
    .in_data ({sh_ff[6:0], nack}),
    .out_valid (rd_valid),
    .out_ready (rd_ready),
    .out_data (rd_data)
  );

  // ===========================================================
  // checks
  chk_strap_int_held: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    $rose(tp_rstn_ff) |-> int_oe_ff && int_o_ff == sel_ff)
    else $error("interrupt line not held at reset release");
  chk_addr_fixed: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    (state_ff != ST_RST && $past(state_ff) != ST_RST) |-> $stable(sel_ff))
    else $error("address pair changed after strap");
  chk_write_dir_bit: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    (go_ff && state_ff == ST_ADDR_W && bit_idx_ff == LAST_DATA_BIT)
      |-> !tx_ff)
    else $error("write address with read direction");
  chk_read_dir_bit: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    (go_ff && state_ff == ST_ADDR_R && bit_idx_ff == LAST_DATA_BIT)
      |-> tx_ff)
    else $error("read address with write direction");
  chk_ptr_before_read: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    (state_ff == ST_RSTART && $past(state_ff) != ST_RSTART)
      |-> $past(state_ff) == ST_PTR_LO)
    else $error("repeated start without pointer phase");
  chk_last_nack: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    (go_ff && state_ff == ST_RDATA && bit_idx_ff == ACK_SLOT)
      |-> tx_ff == (left_ff <= 8'h01))
    else $error("wrong acknowledge on read byte");
  chk_nine_slots: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    (bit_done && byte_state && bit_idx_ff == ACK_SLOT) |=> bit_idx_ff == 4'h0)
    else $error("byte did not end after ninth slot");
  chk_burst_to_stop: assert property (
    @(posedge sys_clk) disable iff (!rstn)
    (state_ff == ST_STOP && $past(state_ff) == ST_WDATA)
      |-> left_ff == 8'h00 || nack_err_ff)
    else $error("write burst stopped early");

endmodule : touch_host_i2c

// [test/touch_target_model.sv]
// behavioural touch target answering on the open-drain serial pins
`timescale 1ns/1ps
module touch_target_model (
  // bus and strap pins
  input wire logic scl,
  input wire logic sda,
  input wire logic rst_line_n,
  input wire logic int_line,
  // pull on the data line
  output logic sda_pull
);
  logic [7:0] mem [0:65535];
  logic [7:0] own_ff = 8'hBA;
  logic [15:0] ptr = 16'h0000;
  logic [7:0] b;
  logic st = 1'b0;
  logic a;

  initial sda_pull = 1'b0;

  // ===========================================================
  // address pair caught when the reset line is released
  always @(posedge rst_line_n) own_ff = int_line ? 8'h28 : 8'hBA;

  always @(negedge sda) if (scl === 1'b1) begin
    disable xfer;
    sda_pull = 1'b0;
    st = 1'b1;
  end

  always @(posedge sda) if (scl === 1'b1) begin
    disable xfer;
    sda_pull = 1'b0;
  end

  // ===========================================================
  // byte slots, only ever as a target
  task rx8();
    repeat (8) @(posedge scl) b = {b[6:0], sda};
  endtask : rx8

  task ack();
    @(negedge scl) sda_pull = 1'b1;
    @(negedge scl) sda_pull = 1'b0;
  endtask : ack

  always begin : xfer
    wait (st);
    st = 1'b0;
    rx8();
    if (b[7:1] == own_ff[7:1]) begin
      ack();
      if (b[0]) begin
        a = 1'b0;
        while (a == 1'b0) begin
          for (int i = 7; i >= 0; i--) begin
            sda_pull = ~mem[ptr][i];
            @(negedge scl);
          end
          sda_pull = 1'b0;
          ptr = ptr + 16'h0001;
          @(posedge scl) a = sda;
          if (a == 1'b0) @(negedge scl);
        end
      end else begin
        rx8();
        ptr[15:8] = b;
        ack();
        rx8();
        ptr[7:0] = b;
        ack();
        forever begin
          rx8();
          mem[ptr] = b;
          ptr = ptr + 16'h0001;
          ack();
        end
      end
    end
  end
endmodule : touch_target_model

// [test/touch_controller_i2c_target_bench.sv]
// self-checking bench of the touch panel serial host
`timescale 1ns/1ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin \
  mismatches++; $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module touch_controller_i2c_target_bench;
  import touch_host_pkg::*;
  localparam int LIM = 30000;
  logic sys_clk = 1'b0, rstn = 1'b0, addr_sel = 1'b0, flip = 1'b0;
  logic cmd_valid = 1'b0, cmd_read = 1'b0, wr_valid = 1'b0;
  logic rd_ready = 1'b0, hold = 1'b0;
  logic [15:0] cmd_reg = 16'h0000;
  logic [7:0] cmd_len = 8'h00, wr_data = 8'h00, rd_data;
  logic cmd_ready, wr_ready, rd_valid, init_done, nack_err, touch_irq;
  logic tp_rstn, int_o, int_oe, scl_oe, sda_oe, sda_pull, scl_o, sda_o;
  logic scl_l, sda_l, int_l;
  int mismatches = 0;
  int tests_run = 0;
  logic [7:0] refm [int];
  logic [7:0] got [$];

  assign scl_l = ~scl_oe;
  assign sda_l = ~(sda_oe | sda_pull);
  assign int_l = int_oe ? int_o : 1'b1;
  always #10 sys_clk = ~sys_clk;

  touch_host_i2c #(.STRAP_RST_CYC(20), .STRAP_HOLD_CYC(20),
    .STRAP_WAIT_CYC(50)) dut (.sys_clk(sys_clk), .rstn(rstn),
    .addr_sel(addr_sel), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_read(cmd_read), .cmd_reg(cmd_reg), .cmd_len(cmd_len),
    .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data),
    .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data),
    .init_done(init_done), .nack_err(nack_err), .touch_irq(touch_irq),
    .tp_rstn(tp_rstn), .int_i(int_l), .int_o(int_o), .int_oe(int_oe),
    .scl_i(scl_l), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_l),
    .sda_o(sda_o), .sda_oe(sda_oe));

  touch_target_model far (.scl(scl_l), .sda(sda_l), .rst_line_n(tp_rstn),
    .int_line(int_l ^ flip), .sda_pull(sda_pull));

  // ===========================================================
  // read stream sink with random stalls
  always @(posedge sys_clk) begin
    rd_ready <= ~hold & 1'($urandom);
    if (rd_valid === 1'b1 && rd_ready === 1'b1) got.push_back(rd_data);
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : test_done

  task automatic boot(input logic s, input logic f);
    rstn <= 1'b0;
    addr_sel <= s;
    flip <= f;
    repeat (4) @(posedge sys_clk);
    rstn <= 1'b1;
  endtask : boot

  task automatic cmd(input logic r, input logic [15:0] a,
    input logic [7:0] n);
    int k;
    k = 0;
    cmd_read <= r;
    cmd_reg <= a;
    cmd_len <= n;
    cmd_valid <= 1'b1;
    do begin @(posedge sys_clk); k++; end
    while (cmd_ready !== 1'b1 && k < LIM);
    cmd_valid <= 1'b0;
    @(posedge sys_clk);
    while (cmd_ready !== 1'b1 && k < LIM) begin @(posedge sys_clk); k++; end
    `CHK("cmd_ready", 1'b1, cmd_ready)
  endtask : cmd

  task automatic put(input logic [7:0] d);
    wr_data <= d;
    wr_valid <= 1'b1;
    do @(posedge sys_clk); while (wr_ready !== 1'b1);
  endtask : put

  task automatic drain(input int n);
    int k;
    k = 0;
    while (got.size() < n && k < 300) begin @(posedge sys_clk); k++; end
    `CHK("rd_count", n, got.size())
  endtask : drain

  // ===========================================================
  // main sequence
  initial begin
    logic [15:0] a;
    logic [7:0] d;
    int n;
    void'($urandom(24703));
    for (int s = 0; s < 2; s++) begin
      boot(1'(s), 1'b0);
      a = 16'($urandom);
      n = 1 + $urandom % 3;
      fork
        cmd(1'b0, a, 8'(n));
        begin
          for (int i = 0; i < n; i++) begin
            d = 8'($urandom);
            refm[16'(a + i)] = d;
            put(d);
          end
          wr_valid <= 1'b0;
        end
      join
      `CHK("pins", 4'hC, {init_done, touch_irq, scl_o, sda_o})
      `CHK("nack_wr", 1'b0, nack_err)
      got.delete();
      hold <= 1'b1;
      fork
        cmd(1'b1, a, 8'(n));
        begin repeat (9000) @(posedge sys_clk); hold <= 1'b0; end
      join
      drain(n);
      for (int i = 0; i < n; i++) `CHK("rd", refm[16'(a + i)], got[i])
      a = a + 16'(n - 1);
      cmd(1'b0, a, 8'h00);
      got.delete();
      cmd(1'b1, a, 8'h00);
      drain(1);
      `CHK("rd_one", refm[a], got[0])
      $display("address pair %0d done", s);
    end
    boot(1'b0, 1'b1);
    fork
      cmd(1'b0, 16'h0000, 8'h01);
      begin
        put(8'h5A);
        wr_valid <= 1'b0;
      end
    join
    `CHK("nack_foreign", 1'b1, nack_err)
    $display("foreign address done");
    test_done();
  end

  initial begin
    repeat (95000) @(posedge sys_clk);
    mismatches++;
    test_done();
  end
endmodule : touch_controller_i2c_target_bench
